// ==== design/smc_pkg.sv ====
// shared constants for the module sideband control ends
// assumes a 25 MHz system clock on both ends
package smc_pkg;
  localparam int CLK_MHZ           = 25;
  // pin timing, in their own units
  localparam int T_SEL_ASSERT_NS   = 2000;
  localparam int T_SEL_DEASSERT_NS = 2000;
  localparam int T_RESET_MIN_NS    = 10000;
  localparam int T_INIT_US         = 2000;
  localparam int T_SCL_QTR_NS      = 2500;
  // cycle counts: least times round up, the scl quarter rounds down
  localparam int SEL_ASSERT_CYC    = (T_SEL_ASSERT_NS * CLK_MHZ + 999) / 1000;
  localparam int SEL_DEASSERT_CYC  = (T_SEL_DEASSERT_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_MIN_CYC     = (T_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC          = T_INIT_US * CLK_MHZ;
  localparam int SCL_QTR_CYC       = T_SCL_QTR_NS * CLK_MHZ / 1000;
  // management map of the module
  localparam logic [6:0] DEV_ADDR7  = 7'h50;
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_FLAGS  = 8'h03;
  localparam logic [7:0] OFF_PWR    = 8'h5d;
  localparam int         ST_NRDY    = 0;
  localparam int         FL_FAULT   = 0;
  localparam int         PW_OVR     = 0;
  localparam int         PW_SET     = 1;
  localparam int         PW_HICLS   = 2;
  localparam logic [2:0] PWR_RST    = 3'h0;
  // controller registers, byte addresses
  localparam logic [4:0] HR_CTRL    = 5'h00;
  localparam logic [4:0] HR_XFER    = 5'h04;
  localparam logic [4:0] HR_STAT    = 5'h08;
  localparam logic [4:0] HR_IRQ     = 5'h0c;
  localparam logic [4:0] HR_MASK    = 5'h10;
  localparam int C_WR  = 0;
  localparam int C_RD  = 1;
  localparam int C_RST = 2;
  localparam int C_LP  = 3;
  localparam int C_FLT = 4;
  localparam int I_DONE = 0;
  localparam int I_INT  = 1;
  localparam int I_PRS  = 2;
endpackage

// ==== design/smc_if.sv ====
// sideband pins between host controller and module
// resolves open-drain lines and the module's internal pull-ups
`timescale 1ns/1ps
interface smc_if;
  logic host_sel_o, host_sel_oe, host_rst_o, host_rst_oe, host_lp_o, host_lp_oe;
  logic host_scl_oe, host_sda_oe, dev_sda_oe, dev_int_oe, dev_prs_oe;
  logic module_select_n, module_reset_n, low_power_pin;
  logic scl, sda, interrupt_n, module_present_n;
  // undriven inputs float to the high level inside the module
  assign module_select_n  = host_sel_oe ? host_sel_o : 1'b1;
  assign module_reset_n   = host_rst_oe ? host_rst_o : 1'b1;
  assign low_power_pin    = host_lp_oe ? host_lp_o : 1'b1;
  // open-drain lines, pulled up on the host board
  assign scl              = ~host_scl_oe;
  assign sda              = ~(host_sda_oe | dev_sda_oe);
  assign interrupt_n      = ~dev_int_oe;
  assign module_present_n = ~dev_prs_oe;
  modport dev (input module_select_n, module_reset_n, low_power_pin, scl, sda,
               output dev_sda_oe, dev_int_oe, dev_prs_oe);
  modport host (output host_sel_o, host_sel_oe, host_rst_o, host_rst_oe, host_lp_o,
                host_lp_oe, host_scl_oe, host_sda_oe,
                input sda, interrupt_n, module_present_n);
endinterface

// ==== design/smc_sync.sv ====
// two-flop synchroniser for pin inputs
// assumes pins idle high; the first stage feeds only the second
`timescale 1ns/1ps
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  // both stages reset to the idle level
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_r <= '1;
      q_o    <= '1;
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // smc_sync

// ==== design/smc_dev.sv ====
// module end: select gating, 2-wire slave, reset, power and interrupt
// assumes the host keeps its own select and reset timing
// Notes on behaviour
// - selected module answers 2-wire commands
// - deselected module ignores and never acknowledges
// - select input rests high when floating
// - host waits deassert time before traffic
// - host waits assert time after selecting
// - reset input rests high when floating
// - long reset pulse restores all settings
// - init timing starts at reset release
// - host ignores status until completion
// - completion shown by interrupt, not-ready clear
// - power-up posts completion without reset
// - low-power pin high forces low power
// - pin plus three software bits set power
// - presence line is grounded by module
// - interrupt low reports fault or status
// - host reads status to find source
// - interrupt is open-collector, pull low only
// - release after status and flags read
`timescale 1ns/1ps
module smc_dev
  import smc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  smc_if.dev        pins,
  input  wire logic fault_i,
  output logic      low_power_o,
  output logic      high_class_o,
  output logic      init_pending_o
);
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_OFF  = 3'b010,
    SL_WDAT = 3'b011,
    SL_RDAT = 3'b100
  } smc_sl_t;

  logic [4:0]  pin_s;
  logic        scl_s, sda_s, sel_n_s, rst_n_s, lp_s;
  logic        scl_q, sda_q, rst_q;
  logic        scl_rise, scl_fall, start_c, stop_c, go_c;
  smc_sl_t     st_r;
  logic [3:0]  cnt_r;
  logic        ack_r, rw_r, mack_r, sda_oe_r;
  logic [7:0]  sh_r, tx_r, ptr_r, rd_c;
  logic        wr_pulse, load_pulse;
  logic [15:0] low_cnt_r;
  logic        long_low_r, full_rst_c;
  logic [31:0] init_cnt_r;
  logic        pend_r, done_c;
  logic [2:0]  pwr_r;
  logic [7:0]  flag_r;
  logic        cmpl_r, seen_st_r, seen_fl_r, int_oe_r, prs_oe_r;

  // pins pass two flops before use
  smc_sync #(.W(5)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .d_i    ({pins.scl, pins.sda, pins.module_select_n, pins.module_reset_n,
              pins.low_power_pin}),
    .q_o    (pin_s)
  );
  assign {scl_s, sda_s, sel_n_s, rst_n_s, lp_s} = pin_s;

  // previous levels for edge and condition detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rst_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      rst_q <= rst_n_s;
    end
  end

  // bus events and gating
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  assign go_c     = ~sel_n_s & ~long_low_r & ~stop_c & ~start_c;
  assign wr_pulse = go_c & scl_fall & ~ack_r & (cnt_r == 4'h8) & (st_r == SL_WDAT);
  assign load_pulse = go_c & scl_fall & ack_r
                    & (((st_r == SL_ADDR) & rw_r) | ((st_r == SL_RDAT) & mack_r));

  // read view of the management map
  always_comb begin
    rd_c = 8'h00;
    if (ptr_r == OFF_STATUS) begin
      rd_c[ST_NRDY] = pend_r;
    end else if (ptr_r == OFF_FLAGS) begin
      rd_c = flag_r;
    end else if (ptr_r == OFF_PWR) begin
      rd_c = {5'h00, pwr_r};
    end
  end

  // 2-wire slave, byte engine and pointer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= SL_IDLE;
      cnt_r    <= 4'h0;
      ack_r    <= 1'b0;
      rw_r     <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      ptr_r    <= 8'h00;
    end else if (ce_i) begin
      if (sel_n_s | long_low_r | stop_c) begin
        st_r     <= SL_IDLE;
        ack_r    <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (start_c) begin
        st_r     <= SL_ADDR;
        cnt_r    <= 4'h0;
        ack_r    <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (scl_rise && st_r != SL_IDLE) begin
        if (!ack_r) begin
          sh_r  <= {sh_r[6:0], sda_s};
          cnt_r <= cnt_r + 4'h1;
        end else begin
          mack_r <= ~sda_s;
        end
      end else if (scl_fall && st_r != SL_IDLE) begin
        if (!ack_r && cnt_r == 4'h8) begin
          cnt_r <= 4'h0;
          ack_r <= 1'b1;
          unique case (st_r)
            SL_ADDR: begin
              if (sh_r[7:1] == DEV_ADDR7) begin
                sda_oe_r <= 1'b1;
                rw_r     <= sh_r[0];
              end else begin
                st_r <= SL_IDLE;
              end
            end
            SL_OFF: begin
              ptr_r    <= sh_r;
              sda_oe_r <= 1'b1;
            end
            SL_WDAT: begin
              ptr_r    <= ptr_r + 8'h01;
              sda_oe_r <= 1'b1;
            end
            SL_RDAT: sda_oe_r <= 1'b0;  // master acks
            SL_IDLE: sda_oe_r <= 1'b0;
          endcase
        end else if (ack_r) begin
          ack_r <= 1'b0;
          if (load_pulse) begin
            st_r     <= SL_RDAT;
            tx_r     <= rd_c;
            ptr_r    <= ptr_r + 8'h01;
            sda_oe_r <= ~rd_c[7];
          end else begin
            sda_oe_r <= 1'b0;
            if (st_r == SL_RDAT) begin
              st_r <= SL_IDLE;
            end else if (st_r == SL_ADDR) begin
              st_r <= SL_OFF;
            end else begin
              st_r <= SL_WDAT;
            end
          end
        end else if (st_r == SL_RDAT) begin
          tx_r     <= {tx_r[6:0], 1'b0};
          sda_oe_r <= ~tx_r[6];
        end
      end
    end
  end

  // reset pin: measure the low level, act on a long one
  assign full_rst_c = long_low_r & rst_n_s & ~rst_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_cnt_r  <= 16'h0000;
      long_low_r <= 1'b0;
    end else if (ce_i) begin
      if (rst_n_s) begin
        low_cnt_r <= 16'h0000;
        if (full_rst_c) begin
          long_low_r <= 1'b0;
        end
      end else if (low_cnt_r == 16'(RESET_MIN_CYC)) begin
        long_low_r <= 1'b1;
      end else begin
        low_cnt_r <= low_cnt_r + 16'h0001;
      end
    end
  end

  // initialization interval, also run after power-up
  assign done_c = pend_r & ~long_low_r & (init_cnt_r == 32'(INIT_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_r     <= 1'b1;
      init_cnt_r <= 32'h0;
    end else if (ce_i) begin
      if (long_low_r) begin
        pend_r     <= 1'b1;
        init_cnt_r <= 32'h0;  // timing starts at release
      end else if (done_c) begin
        pend_r <= 1'b0;
      end else if (pend_r) begin
        init_cnt_r <= init_cnt_r + 32'h1;
      end
    end
  end

  // power control byte and resulting power state
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && long_low_r)) begin
      pwr_r <= PWR_RST;
    end else if (ce_i && wr_pulse && ptr_r == OFF_PWR) begin
      pwr_r <= sh_r[2:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_power_o  <= 1'b1;
      high_class_o <= 1'b0;
    end else if (ce_i) begin
      low_power_o  <= lp_s | (pwr_r[PW_OVR] & pwr_r[PW_SET]);
      high_class_o <= ~lp_s & ~(pwr_r[PW_OVR] & pwr_r[PW_SET])
                    & pwr_r[PW_HICLS];
    end
  end

  // fault flags, cleared by reading the flag byte; a new fault wins
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && long_low_r)) begin
      flag_r <= 8'h00;
    end else if (ce_i) begin
      flag_r <= (flag_r & ~{8{load_pulse && ptr_r == OFF_FLAGS}})
              | {7'h00, fault_i};
    end
  end

  // completion interrupt and its release after both reads
  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && long_low_r)) begin
      cmpl_r    <= 1'b0;
      seen_st_r <= 1'b0;
      seen_fl_r <= 1'b0;
    end else if (ce_i) begin
      if (done_c) begin
        cmpl_r    <= 1'b1;
        seen_st_r <= 1'b0;
        seen_fl_r <= 1'b0;
      end else begin
        if (load_pulse && ptr_r == OFF_STATUS && !pend_r) begin
          seen_st_r <= 1'b1;
        end
        if (load_pulse && ptr_r == OFF_FLAGS) begin
          seen_fl_r <= 1'b1;
        end
        if (seen_st_r && seen_fl_r) begin
          cmpl_r <= 1'b0;
        end
      end
    end
  end

  // pin drivers, all from flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      int_oe_r <= 1'b0;
      prs_oe_r <= 1'b1;
    end else if (ce_i) begin
      int_oe_r <= cmpl_r | (|flag_r);
      prs_oe_r <= 1'b1;
    end
  end
  assign pins.dev_sda_oe = sda_oe_r;
  assign pins.dev_int_oe = int_oe_r;
  assign pins.dev_prs_oe = prs_oe_r;
  assign init_pending_o  = pend_r;
endmodule // smc_dev

// ==== design/smc_host.sv ====
// host controller end: Avalon-MM registers, pin drive, 2-wire master
// assumes a single module on the bus and no clock stretching
`timescale 1ns/1ps
module smc_host
  import smc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  smc_if.host              pins,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq_o
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SEL   = 3'b001,
    H_START = 3'b010,
    H_BITS  = 3'b011,
    H_STOP  = 3'b100,
    H_DESEL = 3'b101
  } smc_hst_t;

  smc_hst_t    st_r;
  logic [2:0]  pin_s;
  logic        sda_s, int_s, prs_s, int_q, prs_q;
  logic        acc_c, wr_c;
  logic [4:0]  ctrl_r;
  logic [7:0]  off_r, wdat_r, rdat_r;
  logic [2:0]  irq_r, mask_r, ev_c;
  logic [15:0] tcnt_r;
  logic [1:0]  q_r;
  logic [3:0]  bit_r;
  logic [1:0]  byte_r;
  logic        rd_r, frame_r, nack_r, done_c, tick_c, rx_c;
  logic [7:0]  cur_c;
  logic        scl_oe_r, sda_oe_r;

  smc_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .d_i    ({pins.sda, pins.interrupt_n, pins.module_present_n}),
    .q_o    (pin_s)
  );
  assign {sda_s, int_s, prs_s} = pin_s;

  // bus access takes effect when waitrequest is low
  assign acc_c = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_c  = avs_write & ~avs_waitrequest;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if (ce_i) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      unique case (avs_address)
        HR_CTRL: avs_readdata <= {27'h0, ctrl_r};
        HR_XFER: avs_readdata <= {8'h00, rdat_r, wdat_r, off_r};
        HR_STAT: avs_readdata <= {28'h0, ~prs_s, ~int_s, nack_r, st_r != H_IDLE};
        HR_IRQ:  avs_readdata <= {29'h0, irq_r};
        HR_MASK: avs_readdata <= {29'h0, mask_r};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // control, transfer and mask registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= 5'h00;
      off_r  <= 8'h00;
      wdat_r <= 8'h00;
      mask_r <= 3'h0;
    end else if (ce_i) begin
      ctrl_r[C_WR] <= 1'b0;
      ctrl_r[C_RD] <= 1'b0;
      if (wr_c && avs_address == HR_CTRL) begin
        ctrl_r <= avs_writedata[4:0];
      end
      if (wr_c && avs_address == HR_XFER && st_r == H_IDLE) begin
        off_r  <= avs_writedata[7:0];
        wdat_r <= avs_writedata[15:8];
      end
      if (wr_c && avs_address == HR_MASK) begin
        mask_r <= avs_writedata[2:0];
      end
    end
  end

  // sticky events, write one to clear, set wins
  assign ev_c[I_DONE] = done_c;
  assign ev_c[I_INT]  = int_q & ~int_s;
  assign ev_c[I_PRS]  = prs_q ^ prs_s;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_r <= 3'h0;
      irq_o <= 1'b0;
      int_q <= 1'b1;
      prs_q <= 1'b1;
    end else if (ce_i) begin
      int_q <= int_s;
      prs_q <= prs_s;
      irq_r <= (irq_r & ~((wr_c && avs_address == HR_IRQ) ? avs_writedata[2:0] : 3'h0))
             | ev_c;
      irq_o <= |(irq_r & mask_r);
    end
  end

  // byte to send in the current frame
  assign tick_c = tcnt_r == 16'(SCL_QTR_CYC - 1);
  assign rx_c   = frame_r & (byte_r == 2'h1);
  assign done_c = (st_r == H_DESEL) & (tcnt_r == 16'(SEL_DEASSERT_CYC - 1));
  always_comb begin
    cur_c = {DEV_ADDR7, frame_r};
    if (byte_r == 2'h1) begin
      cur_c = off_r;
    end else if (byte_r == 2'h2) begin
      cur_c = wdat_r;
    end
  end

  // transaction sequencer and bit engine
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r    <= H_IDLE;
      tcnt_r  <= 16'h0;
      q_r     <= 2'h0;
      bit_r   <= 4'h0;
      byte_r  <= 2'h0;
      rd_r    <= 1'b0;
      frame_r <= 1'b0;
      nack_r  <= 1'b0;
      rdat_r  <= 8'h00;
    end else if (ce_i) begin
      tcnt_r <= (tick_c || st_r == H_IDLE) ? 16'h0 : tcnt_r + 16'h1;
      unique case (st_r)
        H_IDLE: begin
          if (ctrl_r[C_WR] | ctrl_r[C_RD]) begin
            st_r    <= H_SEL;
            rd_r    <= ctrl_r[C_RD];
            frame_r <= 1'b0;
            nack_r  <= 1'b0;
          end
        end
        H_SEL: begin
          if (tcnt_r == 16'(SEL_ASSERT_CYC - 1)) begin
            st_r   <= H_START;
            tcnt_r <= 16'h0;
            q_r    <= 2'h0;
          end
        end
        H_START: begin
          if (tick_c) begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h2) begin
              st_r   <= H_BITS;
              q_r    <= 2'h0;
              bit_r  <= 4'h0;
              byte_r <= 2'h0;
            end
          end
        end
        H_BITS: begin
          if (tick_c) begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h2) begin
              if (bit_r == 4'h8 && !rx_c && sda_s) begin
                nack_r <= 1'b1;
              end
              if (bit_r != 4'h8 && rx_c) begin
                rdat_r <= {rdat_r[6:0], sda_s};
              end
            end
            if (q_r == 2'h3) begin
              bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                byte_r <= byte_r + 2'h1;
                if (byte_r == ((rd_r | frame_r) ? 2'h1 : 2'h2)) begin
                  st_r <= H_STOP;
                end
              end
            end
          end
        end
        H_STOP: begin
          if (tick_c) begin
            q_r <= q_r + 2'h1;
            if (q_r == 2'h2) begin
              q_r <= 2'h0;
              if (rd_r && !frame_r) begin
                st_r    <= H_START;
                frame_r <= 1'b1;
              end else begin
                st_r   <= H_DESEL;
                tcnt_r <= 16'h0;
              end
            end
          end
        end
        H_DESEL: begin
          if (done_c) begin
            st_r <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // pin drivers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (ce_i) begin
      scl_oe_r <= ((st_r == H_START) & (q_r == 2'h2))
                | ((st_r == H_BITS) & ~q_r[1]) | ((st_r == H_STOP) & (q_r == 2'h0));
      sda_oe_r <= ((st_r == H_START) & (q_r != 2'h0)) | ((st_r == H_STOP) & (q_r != 2'h2))
                | ((st_r == H_BITS) & (bit_r != 4'h8) & ~rx_c & ~cur_c[3'(7 - bit_r)]);
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pins.host_sel_o  <= 1'b1;
      pins.host_sel_oe <= 1'b1;
      pins.host_rst_o  <= 1'b1;
      pins.host_rst_oe <= 1'b1;
      pins.host_lp_o   <= 1'b0;
      pins.host_lp_oe  <= 1'b1;
    end else if (ce_i) begin
      pins.host_sel_o  <= (st_r == H_IDLE) | (st_r == H_DESEL);
      pins.host_sel_oe <= ~ctrl_r[C_FLT];
      pins.host_rst_o  <= ~ctrl_r[C_RST];
      pins.host_rst_oe <= ~ctrl_r[C_FLT];
      pins.host_lp_o   <= ctrl_r[C_LP];
      pins.host_lp_oe  <= ~ctrl_r[C_FLT];
    end
  end
  assign pins.host_scl_oe = scl_oe_r;
  assign pins.host_sda_oe = sda_oe_r;
endmodule // smc_host

// ==== testbench/smc_assertions.sv ====
// checker on the sideband pins and module power outputs
// assumes one clock domain, placed beside the pin interface
`timescale 1ns/1ps
module smc_assertions
  import smc_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC
) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic module_select_n,
  input  wire logic module_reset_n,
  input  wire logic low_power_pin,
  input  wire logic interrupt_n,
  input  wire logic module_present_n,
  input  wire logic dev_sda_oe,
  input  wire logic init_pending_o,
  input  wire logic low_power_o,
  input  wire logic high_class_o
);
  logic        rn_q;
  int unsigned lowc;
  int unsigned hic;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // last low pulse length and time since the reset pin was low
  always_ff @(posedge clk_i) begin
    rn_q <= module_reset_n;
    if (srst_i) lowc <= 0;
    else if (!module_reset_n) lowc <= rn_q ? 1 : lowc + 1;
    if (srst_i || !module_reset_n) hic <= 0;
    else hic <= hic + 1;
  end
  // pin and power relations
  property p_quiet; module_select_n [*4] |-> !dev_sda_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("data driven while unselected");
  property p_prs; module_present_n == 1'b0; endproperty
  a_prs: assert property (p_prs) else $error("presence line high");
  property p_lp; low_power_pin [*5] |-> low_power_o; endproperty
  a_lp: assert property (p_lp) else $error("pin high, not low power");
  property p_cls; high_class_o |-> !low_power_o; endproperty
  a_cls: assert property (p_cls) else $error("upper class in low power");
  property p_rise; $rose(init_pending_o) |-> lowc + 4 >= RESET_MIN_CYC; endproperty
  a_rise: assert property (p_rise) else $error("short pulse started init");
  property p_hold;
    $rose(module_reset_n) && lowc > RESET_MIN_CYC + 4 |-> ##4 init_pending_o [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("pending not held");
  property p_time;
    $fell(init_pending_o) |-> hic + 2 >= INIT_CYCLES && hic <= INIT_CYCLES + 8;
  endproperty
  a_time: assert property (p_time) else $error("init length wrong");
  property p_done; $fell(init_pending_o) |-> ##[0:3] !interrupt_n; endproperty
  a_done: assert property (p_done) else $error("no completion interrupt");
endmodule // smc_assertions

// ==== testbench/module_sideband_control_test.sv ====
// bench: host controller and module joined by the pin interface
// assumes design files compiled first; init shortened to 200 cycles
`timescale 1ns/1ps
module module_sideband_control_test;
  import smc_pkg::*;
  // row: power byte, pin drive, expected low power, expected class
  typedef struct packed {logic [2:0] pwr; logic pin; logic lp; logic hc;} smc_row_t;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        fault_i = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, ctl, q;
  logic        avs_waitrequest, irq_o, low_power_o, high_class_o, init_pending_o;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  smc_row_t    rows [4] = '{6'h26, 6'h21, 6'h3a, 6'h29};
  smc_if sb ();
  smc_dev #(.INIT_CYCLES(200)) i_smc_dev (.clk_i, .srst_i, .ce_i(1'b1), .pins(sb.dev), .fault_i,
    .low_power_o, .high_class_o, .init_pending_o);
  smc_host i_smc_host (.clk_i, .srst_i, .ce_i(1'b1), .pins(sb.host), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq_o);
  smc_assertions #(.INIT_CYCLES(200)) i_smc_assertions (.clk_i, .srst_i,
    .module_select_n(sb.module_select_n), .module_reset_n(sb.module_reset_n),
    .low_power_pin(sb.low_power_pin), .interrupt_n(sb.interrupt_n),
    .module_present_n(sb.module_present_n), .dev_sda_oe(sb.dev_sda_oe), .init_pending_o,
    .low_power_o, .high_class_o);
  always #20 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one bus access held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk(avs_waitrequest, 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask
  // one serial transfer; read data lands in q[23:16]
  task automatic xfer(input logic rd, input logic [7:0] off, input logic [7:0] d);
    int n;
    n = 0;
    av(1'b1, HR_XFER, {16'h0, d, off});
    av(1'b1, HR_CTRL, ctl | (rd ? 32'h2 : 32'h1));
    do begin
      av(1'b0, HR_IRQ, 32'h0);
      n++;
    end while (q[I_DONE] !== 1'b1 && n < 9000);
    chk(q[I_DONE], 1'b1);
    av(1'b1, HR_IRQ, 32'h1);
    av(1'b0, HR_XFER, 32'h0);
  endtask
  task automatic wait_pend;
    int n;
    n = 0;
    while (init_pending_o !== 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(init_pending_o, 1'b0);
    repeat (4) @(posedge clk_i);
  endtask
  // main sequence
  initial begin
    ctl = 32'h0;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    wait_pend();
    chk(sb.interrupt_n, 1'b0);
    av(1'b0, HR_IRQ, 32'h0);
    chk(q[I_INT], 1'b1);
    chk(irq_o, 1'b0);
    av(1'b1, HR_MASK, 32'h2);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    xfer(1'b1, OFF_STATUS, 8'h00);
    chk(q[16+ST_NRDY], 1'b0);
    chk(sb.interrupt_n, 1'b0);
    fault_i <= 1'b1;
    @(posedge clk_i);
    fault_i <= 1'b0;
    xfer(1'b1, OFF_FLAGS, 8'h00);
    chk(q[16+FL_FAULT], 1'b1);
    repeat (4) @(posedge clk_i);
    chk(sb.interrupt_n, 1'b1);
    av(1'b1, HR_IRQ, 32'h7);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    $display("test interrupt done");
    foreach (rows[i]) begin
      ctl = {28'h0, rows[i].pin, 3'h0};
      xfer(1'b0, OFF_PWR, {5'h00, rows[i].pwr});
      chk(low_power_o, rows[i].lp);
      chk(high_class_o, rows[i].hc);
    end
    xfer(1'b1, OFF_PWR, 8'h00);
    chk(q[23:16], 8'h05);
    $display("test power done");
    // short pulse ignored, long pulse restores defaults
    av(1'b1, HR_CTRL, 32'h4);
    av(1'b1, HR_CTRL, 32'h0);
    repeat (20) @(posedge clk_i);
    chk(init_pending_o, 1'b0);
    av(1'b1, HR_CTRL, 32'h4);
    repeat (RESET_MIN_CYC + 20) @(posedge clk_i);
    av(1'b1, HR_CTRL, 32'h0);
    repeat (10) @(posedge clk_i);
    chk(init_pending_o, 1'b1);
    wait_pend();
    chk({low_power_o, high_class_o, sb.interrupt_n}, 3'h0);
    $display("test reset done");
    // floated select: no acknowledge, released data line
    ctl = 32'h10;
    xfer(1'b1, OFF_STATUS, 8'h00);
    chk(q[23:16], 8'hff);
    chk(sb.module_select_n, 1'b1);
    av(1'b0, HR_STAT, 32'h0);
    chk(q[1], 1'b1);
    chk(q[3:2], 2'h3);
    chk(low_power_o, 1'b1);
    $display("test deselect done");
    wrap_up();
  end
endmodule // module_sideband_control_test
